// ### sfpe_map.vh
`ifndef SFPE_MAP_VH
`define SFPE_MAP_VH

// command opcodes, sent most significant bit first
`define SFPE_OP_READ_ID      8'hAB
`define SFPE_OP_PROGRAM      8'h02
`define SFPE_OP_BULK_ERASE   8'hC7
`define SFPE_OP_SECTOR_ERASE 8'hD8

// status bit positions
`define SFPE_ST_WIP 0
`define SFPE_ST_WEL 1

// field sizes
`define SFPE_ADDR_W      24
`define SFPE_PAGE_W      8
`define SFPE_FIFO_DEPTH  8
`define SFPE_SECTOR_BITS 16
`define SFPE_ADDR_BITS   23

// system clock rate
`define SFPE_CLK_KHZ 40'd100000

// self-timed cycle lengths, typical figures; the limits are 5 ms, 6/10/40/160 s and 3 s
`define SFPE_T_PROG_US   40'd1500
`define SFPE_T_BULK0_MS  40'd3000
`define SFPE_T_BULK1_MS  40'd5000
`define SFPE_T_BULK2_MS  40'd17000
`define SFPE_T_BULK3_MS  40'd68000
`define SFPE_T_SECTOR_MS 40'd2000

`define SFPE_PROG_CYC   (`SFPE_T_PROG_US * `SFPE_CLK_KHZ / 40'd1000)
`define SFPE_BULK0_CYC  (`SFPE_T_BULK0_MS * `SFPE_CLK_KHZ)
`define SFPE_BULK1_CYC  (`SFPE_T_BULK1_MS * `SFPE_CLK_KHZ)
`define SFPE_BULK2_CYC  (`SFPE_T_BULK2_MS * `SFPE_CLK_KHZ)
`define SFPE_BULK3_CYC  (`SFPE_T_BULK3_MS * `SFPE_CLK_KHZ)
`define SFPE_SECTOR_CYC (`SFPE_T_SECTOR_MS * `SFPE_CLK_KHZ)

`endif

// ### sfpe_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sfpe_map.vh"

module sfpe_fifo #(
    parameter W     = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0]  mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0]   cnt_q;
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    always @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// Operation
// RL1: identification read opens with opcode 0xAB, most significant bit first.
// RL2: identification opcode during a program or erase cycle is ignored.
// RL3: after three dummy bytes the code shifts out on falling clock edges.
// RL4: the code repeats while select stays low and clocks continue.
// RL5: page program opcode is 0x02 and needs the write-enable latch set.
// RL6: host keeps select low through opcode, three address bytes, data.
// RL7: data past page end wraps to the start of the same page.
// RL8: beyond 256 bytes only the final 256 are programmed.
// RL9: fewer bytes program their addresses; rest of the page untouched.
// RL10: programming starts only if select rises right after a whole byte.
// RL11: write-enable latch clears before each program completes; here a set arriving in the same cycle as the start keeps it set.
// RL12: select rising after valid program sequence starts a self-timed cycle.
// RL13: write-in-progress reads 1 during the cycle and 0 afterwards.
// RL14: bulk erase opcode 0xC7 needs write enable and sets all to ones.
// RL15: bulk erase starts when select rises right after the opcode.
// RL16: bulk erase time for the two small variants, 3 s or 5 s.
// RL17: bulk erase time for the two large variants, 17 s or 68 s.
// RL18: sector erase opcode 0xD8 needs write enable and erases the sector.
// RL19: sector erase takes three address bytes; any inside address selects it.
// RL20: host raises select to end the sector erase command.
// RL21: sector erase starts when select rises and takes about 2 s.
// RL22: either erase holds write-in-progress and clears the latch; here a set arriving in the same cycle as the start keeps it set.
// RL23: address bits above the device density are ignored.
// RL24: write-in-progress sits at status bit 0, readable at any time.
// RL25: every incoming bit is sampled on a rising serial clock edge.
// RL26: program or erase opcode with the latch clear is ignored.
// RL27: opcode decoding begins only after select goes high then low.
module sfpe_top #(
    parameter [7:0]  ID_CODE     = 8'h5A,  // arbitrary value
    parameter        ADDR_BITS   = `SFPE_ADDR_BITS,
    parameter        SECTOR_BITS = `SFPE_SECTOR_BITS,
    parameter        FIFO_DEPTH  = `SFPE_FIFO_DEPTH,
    parameter [39:0] PROG_CYC    = `SFPE_PROG_CYC,
    parameter [39:0] BULK_CYC    = `SFPE_BULK3_CYC,
    parameter [39:0] SECT_CYC    = `SFPE_SECTOR_CYC
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        serial_clock,
    input  wire        chip_select_n,
    input  wire        serial_command_in,
    output reg         serial_data_out,
    output reg         serial_data_oe_n,
    input  wire        write_enable_set,
    output wire [7:0]  status_q,
    output wire        mem_wr_valid,
    input  wire        mem_wr_ready,
    output wire [23:0] mem_wr_addr,
    output wire [7:0]  mem_wr_data,
    output reg         erase_valid,
    output reg         erase_bulk,
    output reg  [23:0] erase_addr
);
    localparam [7:0] ST_IDLE  = 8'h01;
    localparam [7:0] ST_OP    = 8'h02;
    localparam [7:0] ST_ADDR  = 8'h04;
    localparam [7:0] ST_DUMMY = 8'h08;
    localparam [7:0] ST_ID    = 8'h10;
    localparam [7:0] ST_DATA  = 8'h20;
    localparam [7:0] ST_ARM   = 8'h40;
    localparam [7:0] ST_IGN   = 8'h80;
    localparam [2:0] E_IDLE  = 3'h1;
    localparam [2:0] E_DRAIN = 3'h2;
    localparam [2:0] E_WAIT  = 3'h4;
    localparam [31:0] AMASK32 = (32'h1 << ADDR_BITS) - 32'h1;
    localparam [31:0] SMASK32 = ~((32'h1 << SECTOR_BITS) - 32'h1);
    localparam [23:0] AMASK   = AMASK32[23:0];
    localparam [23:0] SMASK   = SMASK32[23:0];
    // pins: bit 0 clock, bit 1 data in, bit 2 select
    wire [2:0] pin_in = {chip_select_n, serial_command_in, serial_clock};
    reg  [2:0] s1_q;
    reg  [2:0] s2_q;
    reg  [2:0] s3_q;
    reg  [2:0] f_q;
    reg  [2:0] fp_q;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    s1_q[g] <= (g == 2);
                    s2_q[g] <= (g == 2);
                    s3_q[g] <= (g == 2);
                    f_q[g]  <= (g == 2);
                    fp_q[g] <= (g == 2);
                end else begin
                    s1_q[g] <= pin_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // a change only counts once two stages agree
                    if (s2_q[g] == s3_q[g]) begin
                        f_q[g] <= s3_q[g];
                    end
                    fp_q[g] <= f_q[g];
                end
            end
        end
    endgenerate
    wire sck_rise = f_q[0] & ~fp_q[0];
    wire sck_fall = ~f_q[0] & fp_q[0];
    wire sdi      = f_q[1];
    wire cs_high  = f_q[2];
    wire cs_rise  = f_q[2] & ~fp_q[2];
    reg [7:0]   state_q;
    reg [7:0]   op_q;
    reg [7:0]   sh_q;
    reg [4:0]   bits_q;
    reg [23:0]  addr_q;
    reg [7:0]   wr_ptr_q;
    reg         any_byte_q;
    reg [2:0]   id_idx_q;
    reg [7:0]   page_q [0:255];
    reg [255:0] pvalid_q;
    reg [2:0]   eng_q;
    reg [7:0]   idx_q;
    reg [39:0]  timer_q;
    reg         wip_q;
    reg         wel_q;
    wire [7:0] nsh = {sh_q[6:0], sdi};
    wire       may_write = ~wip_q & wel_q;
    wire       byte_done = sck_rise & (state_q == ST_DATA) & (bits_q == 5'd7);
    wire       go_prog = cs_rise & (state_q == ST_DATA) & (bits_q == 5'd0) & any_byte_q; // [RL10]
    wire       go_erase = cs_rise & (state_q == ST_ARM); // [RL15] [RL20] [RL21]
    assign status_q = {6'h00, wel_q, wip_q}; // [RL24]
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q          <= ST_IDLE;
            op_q             <= 8'h00;
            sh_q             <= 8'h00;
            bits_q           <= 5'h00;
            addr_q           <= 24'h000000;
            wr_ptr_q         <= 8'h00;
            any_byte_q       <= 1'b0;
            id_idx_q         <= 3'h7;
            serial_data_out  <= 1'b0;
            serial_data_oe_n <= 1'b1;
            pvalid_q         <= {256{1'b0}};
        end else if (cs_high) begin
            state_q          <= ST_IDLE;
            serial_data_oe_n <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            state_q <= ST_OP; // [RL27]
            bits_q  <= 5'h00;
        end else if (sck_rise) begin // [RL25]
            case (state_q)
                ST_OP: begin
                    sh_q   <= nsh;
                    bits_q <= bits_q + 5'd1;
                    if (bits_q == 5'd7) begin
                        bits_q <= 5'h00;
                        op_q   <= nsh;
                        case (nsh)
                            `SFPE_OP_READ_ID: begin
                                state_q <= wip_q ? ST_IGN : ST_DUMMY; // [RL1] [RL2]
                            end
                            `SFPE_OP_PROGRAM: begin
                                state_q    <= may_write ? ST_ADDR : ST_IGN; // [RL5] [RL26]
                                any_byte_q <= 1'b0;
                                if (may_write) begin
                                    pvalid_q <= {256{1'b0}}; // [RL9]
                                end
                            end
                            `SFPE_OP_BULK_ERASE: begin
                                state_q <= may_write ? ST_ARM : ST_IGN; // [RL14] [RL26]
                            end
                            `SFPE_OP_SECTOR_ERASE: begin
                                state_q <= may_write ? ST_ADDR : ST_IGN; // [RL18] [RL26]
                            end
                            default: begin
                                state_q <= ST_IGN;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[22:0], sdi};
                    bits_q <= bits_q + 5'd1;
                    if (bits_q == 5'd23) begin
                        bits_q   <= 5'h00;
                        wr_ptr_q <= {addr_q[6:0], sdi};
                        state_q  <= (op_q == `SFPE_OP_PROGRAM) ? ST_DATA : ST_ARM; // [RL19]
                    end
                end
                ST_DUMMY: begin
                    bits_q <= bits_q + 5'd1;
                    if (bits_q == 5'd23) begin
                        bits_q   <= 5'h00;
                        id_idx_q <= 3'h7;
                        state_q  <= ST_ID; // [RL3]
                    end
                end
                ST_DATA: begin
                    sh_q   <= nsh;
                    bits_q <= (bits_q == 5'd7) ? 5'h00 : bits_q + 5'd1;
                    if (byte_done) begin
                        // the pointer wraps inside the page, so later bytes overwrite earlier ones
                        pvalid_q[wr_ptr_q] <= 1'b1; // [RL9]
                        wr_ptr_q           <= wr_ptr_q + 8'd1; // [RL7] [RL8]
                        any_byte_q         <= 1'b1;
                    end
                end
                ST_ARM: begin
                    // extra bits after the command void it
                    state_q <= ST_IGN; // [RL15]
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end else if (sck_fall & (state_q == ST_ID)) begin
            serial_data_out  <= ID_CODE[id_idx_q]; // [RL3]
            serial_data_oe_n <= 1'b0;
            id_idx_q         <= id_idx_q - 3'd1; // [RL4]
        end
    end
    always @(posedge clk_sys) begin
        if (byte_done & ~cs_high) begin
            page_q[wr_ptr_q] <= nsh;
        end
    end
    wire        fifo_in_ready;
    wire        fifo_in_valid = (eng_q == E_DRAIN) & pvalid_q[idx_q];
    wire [23:0] page_base = addr_q & AMASK & 24'hFFFF00; // [RL23]
    wire [31:0] fifo_in_data = {page_base[23:8], idx_q, page_q[idx_q]};
    wire [31:0] fifo_out_data;
    wire        advance = ~pvalid_q[idx_q] | fifo_in_ready;
    assign mem_wr_addr = fifo_out_data[31:8];
    assign mem_wr_data = fifo_out_data[7:0];
    sfpe_fifo #(
        .W     (32),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (mem_wr_valid),
        .out_ready (mem_wr_ready),
        .out_data  (fifo_out_data)
    );
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eng_q       <= E_IDLE;
            idx_q       <= 8'h00;
            timer_q     <= 40'h0000000000;
            wip_q       <= 1'b0;
            wel_q       <= 1'b0;
            erase_valid <= 1'b0;
            erase_bulk  <= 1'b0;
            erase_addr  <= 24'h000000;
        end else begin
            erase_valid <= 1'b0;
            // a set arriving with the start still wins
            if (write_enable_set & ~wip_q) begin
                wel_q <= 1'b1;
            end else if (go_prog | go_erase) begin
                wel_q <= 1'b0; // [RL11] [RL22]
            end
            if (timer_q != 40'h0000000000) begin
                timer_q <= timer_q - 40'd1;
            end
            case (eng_q)
                E_IDLE: begin
                    idx_q <= 8'h00;
                    if (go_prog) begin
                        eng_q   <= E_DRAIN; // [RL12]
                        timer_q <= PROG_CYC;
                        wip_q   <= 1'b1; // [RL13]
                    end else if (go_erase) begin
                        eng_q       <= E_WAIT;
                        wip_q       <= 1'b1; // [RL22]
                        erase_valid <= 1'b1;
                        if (op_q == `SFPE_OP_BULK_ERASE) begin
                            erase_bulk <= 1'b1; // [RL14]
                            erase_addr <= 24'h000000;
                            timer_q    <= BULK_CYC; // [RL16] [RL17]
                        end else begin
                            erase_bulk <= 1'b0;
                            erase_addr <= addr_q & AMASK & SMASK; // [RL18] [RL19] [RL23]
                            timer_q    <= SECT_CYC; // [RL21]
                        end
                    end
                end
                E_DRAIN: begin
                    // memory back-pressure stalls the walk through the page
                    if (advance) begin
                        idx_q <= idx_q + 8'd1;
                        if (idx_q == 8'hFF) begin
                            eng_q <= E_WAIT;
                        end
                    end
                end
                E_WAIT: begin
                    // status stays busy until the memory has taken every byte
                    if ((timer_q == 40'h0000000000) & ~mem_wr_valid) begin
                        wip_q <= 1'b0; // [RL13] [RL22]
                        eng_q <= E_IDLE;
                    end
                end
                default: begin
                    eng_q <= E_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### sfpe_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfpe_top_asserts #(
    parameter        ADDR_BITS   = 23,
    parameter        SECTOR_BITS = 16,
    parameter [39:0] PROG_CYC    = 40'd200,
    parameter [39:0] BULK_CYC    = 40'd300,
    parameter [39:0] SECT_CYC    = 40'd250
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        chip_select_n,
    input wire logic        serial_data_oe_n,
    input wire logic [7:0]  status_q,
    input wire logic        mem_wr_valid,
    input wire logic        mem_wr_ready,
    input wire logic [23:0] mem_wr_addr,
    input wire logic [7:0]  mem_wr_data,
    input wire logic        erase_valid,
    input wire logic        erase_bulk,
    input wire logic [23:0] erase_addr
);
    logic [39:0] cnt_q;
    logic        er_q;
    logic        bulk_q;
    wire  [39:0] exp_cyc = bulk_q ? BULK_CYC : SECT_CYC;
    // er_q tells erase from program; a program always pushes bytes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 40'h0;
            er_q <= 1'b0;
            bulk_q <= 1'b0;
        end else begin
            cnt_q <= status_q[0] ? cnt_q + 40'h1 : 40'h0;
            if (erase_valid) begin
                er_q <= 1'b1;
                bulk_q <= erase_bulk;
            end else if (mem_wr_valid) begin
                er_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence wip_on_s;
        status_q[0] && !status_q[1];
    endsequence
    sequence held_s;
        mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
    endsequence
    oe_idle_a: assert property (chip_select_n [*8] |-> serial_data_oe_n)
        else $error("output enabled while deselected");
    erase_start_a: assert property (erase_valid |-> ##[0:1] wip_on_s)
        else $error("erase without busy or with latch set");
    erase_pulse_a: assert property (erase_valid |=> !erase_valid)
        else $error("erase request longer than one cycle");
    bulk_addr_a: assert property (erase_valid && erase_bulk |-> erase_addr == 24'h000000)
        else $error("bulk erase address not zero");
    sect_base_a: assert property (erase_valid && !erase_bulk |->
        erase_addr[SECTOR_BITS-1:0] == 0 && (erase_addr >> ADDR_BITS) == 0)
        else $error("sector address not a masked base");
    wr_mask_a: assert property (mem_wr_valid |-> (mem_wr_addr >> ADDR_BITS) == 0)
        else $error("write address above density");
    wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> held_s)
        else $error("write head changed while stalled");
    wel_clear_a: assert property ($rose(status_q[0]) |-> ##[0:1] !status_q[1])
        else $error("latch not cleared at cycle start");
    erase_time_a: assert property ($fell(status_q[0]) && er_q |->
        cnt_q + 40'd3 >= exp_cyc && cnt_q <= exp_cyc + 40'd3)
        else $error("erase cycle length wrong");
    prog_time_a: assert property ($fell(status_q[0]) && !er_q |-> cnt_q + 40'd1 >= PROG_CYC)
        else $error("program cycle too short");
    status_pad_a: assert property (status_q[7:2] == 6'h00)
        else $error("status upper bits not zero");
endmodule
bind sfpe_top sfpe_top_asserts #(
    .ADDR_BITS(ADDR_BITS), .SECTOR_BITS(SECTOR_BITS), .PROG_CYC(PROG_CYC),
    .BULK_CYC(BULK_CYC), .SECT_CYC(SECT_CYC)
) u_chk (
    .clk_sys(clk_sys), .rst(rst), .chip_select_n(chip_select_n),
    .serial_data_oe_n(serial_data_oe_n), .status_q(status_q), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .erase_valid(erase_valid), .erase_bulk(erase_bulk), .erase_addr(erase_addr)
);
`default_nettype wire

// ### sfpe_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfpe_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic        mem_wr_valid,
    output var  logic        mem_wr_ready,
    input  wire logic [23:0] mem_wr_addr,
    input  wire logic [7:0]  mem_wr_data,
    input  wire logic        erase_valid,
    input  wire logic        erase_bulk,
    input  wire logic [23:0] erase_addr
);
    logic [7:0]  mem [0:255];
    logic        slow_q;
    int          n_wr;
    int          n_er;
    logic        er_bulk;
    logic [23:0] er_addr;
    logic [15:0] wr_hi;
    // half rate when not stalled, so the design sees back-pressure either way
    assign mem_wr_ready = !stall && slow_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slow_q <= 1'b0;
            n_wr <= 0;
            n_er <= 0;
        end else begin
            slow_q <= !slow_q;
            if (mem_wr_valid && mem_wr_ready) begin
                mem[mem_wr_addr[7:0]] <= mem_wr_data;
                wr_hi <= mem_wr_addr[23:8];
                n_wr <= n_wr + 1;
            end
            if (erase_valid) begin
                for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
                n_er <= n_er + 1;
                er_bulk <= erase_bulk;
                er_addr <= erase_addr;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_sfpe_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sfpe_top;
    localparam [7:0] ID = 8'hC3; // arbitrary value
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        serial_clock = 1'b0;
    logic        chip_select_n = 1'b1;
    logic        serial_command_in = 1'b0;
    logic        write_enable_set = 1'b0;
    logic        stall = 1'b0;
    wire         serial_data_out;
    wire         serial_data_oe_n;
    wire  [7:0]  status_q;
    wire         mem_wr_valid;
    wire         mem_wr_ready;
    wire  [23:0] mem_wr_addr;
    wire  [7:0]  mem_wr_data;
    wire         erase_valid;
    wire         erase_bulk;
    wire  [23:0] erase_addr;
    int          n_mismatch = 0;
    int          n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    sfpe_top #(.ID_CODE(ID), .PROG_CYC(40'd200), .BULK_CYC(40'd300), .SECT_CYC(40'd250)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_command_in(serial_command_in),
        .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
        .write_enable_set(write_enable_set), .status_q(status_q), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .erase_valid(erase_valid), .erase_bulk(erase_bulk), .erase_addr(erase_addr));
    sfpe_mem_model u_mem (
        .clk_sys(clk_sys), .rst(rst), .stall(stall), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .erase_valid(erase_valid), .erase_bulk(erase_bulk), .erase_addr(erase_addr));
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // the output is read just before the next rise, long after the fall moved it
    // pin edges can meet a clk_sys edge, so they land in the nonblocking region
    task automatic bit_tx(input logic b, output logic o);
        serial_command_in <= b;
        #62.5;
        o = serial_data_out;
        serial_clock <= 1'b1;
        #62.5;
        serial_clock <= 1'b0;
    endtask
    task automatic byte_tx(input logic [7:0] v);
        logic o;
        for (int i = 7; i >= 0; i--) bit_tx(v[i], o);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a);
        chip_select_n = 1'b0;
        #100;
        byte_tx(op);
        byte_tx(a[23:16]);
        byte_tx(a[15:8]);
        byte_tx(a[7:0]);
    endtask
    task automatic desel();
        #60;
        chip_select_n <= 1'b1;
        serial_command_in <= ~serial_command_in;
        #200;
    endtask
    task automatic wel();
        @(negedge clk_sys) write_enable_set = 1'b1;
        @(negedge clk_sys) write_enable_set = 1'b0;
        @(negedge clk_sys) chk(status_q[1], 1);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (status_q[0] !== 1'b0 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(status_q[0], 0);
    endtask
    task automatic read_id(input logic active);
        logic [15:0] got;
        logic        o;
        cmd(8'hAB, 24'h000000);
        for (int i = 15; i >= 0; i--) begin
            bit_tx(1'b0, o);
            got[i] = o;
        end
        if (active) begin
            chk(got, {ID, ID});
            chk(serial_data_oe_n, 0);
        end else begin
            chk(serial_data_oe_n, 1);
        end
        desel();
        chk(serial_data_oe_n, 1);
    endtask
    task automatic t_bulk();
        wel();
        chip_select_n = 1'b0;
        #100;
        byte_tx(8'hC7);
        desel();
        chk(status_q[1:0], 2'b01);
        chk(u_mem.er_bulk, 1);
        wait_idle();
        chk(u_mem.mem[8'h5C], 8'hFF);
    endtask
    task automatic t_sector();
        wel();
        cmd(8'hD8, 24'h9A1234);
        desel();
        chk(status_q[1:0], 2'b01);
        chk(u_mem.n_er, 2);
        chk(u_mem.er_addr, 24'h1A0000);
        chk(u_mem.er_bulk, 0);
        wait_idle();
    endtask
    task automatic t_refuse();
        logic o;
        cmd(8'h02, 24'h000010);
        byte_tx(8'h55);
        desel();
        chk(status_q[1:0], 2'b00);
        wel();
        cmd(8'h02, 24'h000010);
        byte_tx(8'h55);
        for (int i = 0; i < 4; i++) bit_tx(1'b1, o);
        desel();
        chk(status_q[0], 0);
        chk(u_mem.n_wr, 0);
        cmd(8'hD8, 24'h010000);
        bit_tx(1'b1, o);
        desel();
        chk(status_q[0], 0);
        chk(u_mem.n_er, 2);
    endtask
    task automatic t_prog();
        @(negedge clk_sys) stall = 1'b1;
        wel();
        cmd(8'h02, 24'h8012FE);
        for (int n = 0; n < 10; n++) byte_tx(8'hA0 + 8'(n));
        desel();
        chk(status_q[1:0], 2'b01);
        read_id(1'b0);
        chk(status_q[0], 1);
        chk(mem_wr_valid, 1);
        chk(u_mem.n_wr, 0);
        @(negedge clk_sys) stall = 1'b0;
        wait_idle();
        chk(u_mem.n_wr, 10);
        chk(u_mem.mem[8'hFF], 8'hA1);
        chk(u_mem.mem[8'h07], 8'hA9);
        chk(u_mem.mem[8'h08], 8'hFF);
        chk(u_mem.wr_hi, 16'h0012);
    endtask
    task automatic t_long();
        wel();
        cmd(8'h02, 24'h001200);
        for (int n = 0; n < 258; n++) byte_tx(8'(n >> 1));
        desel();
        wait_idle();
        chk(u_mem.n_wr, 266);
        chk(u_mem.mem[8'h00], 8'h80);
        chk(u_mem.mem[8'h01], 8'h80);
        chk(u_mem.mem[8'h02], 8'h01);
        chk(u_mem.mem[8'hFF], 8'h7F);
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        read_id(1'b1);
        t_bulk();
        t_sector();
        t_refuse();
        t_prog();
        t_long();
        results();
    end
    initial begin
        #900000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
